// File: design/irq_sel_pkg.sv
// constants shared by the interrupt source select block
package irq_sel_pkg;
  // =====================================================
  // register map
  localparam logic [7:0] ADDR_IRQ_A    = 8'h30;
  localparam logic [7:0] ADDR_IRQ_B    = 8'h31;
  localparam logic [7:0] ADDR_RSVD     = 8'h32;
  localparam logic [7:0] ADDR_FLAG_DAC = 8'h2C;
  localparam logic [7:0] ADDR_FLAG_ADC = 8'h2D;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] FLAG_RESET    = 8'h00;
  // =====================================================
  // control register fields, also the index of each source event
  localparam int BIT_HEADSET  = 7;
  localparam int BIT_BUTTON   = 6;
  localparam int BIT_COMP     = 5;
  localparam int BIT_NOISE    = 4;
  localparam int BIT_SHORT    = 3;
  localparam int BIT_ENGINE   = 2;
  localparam int BIT_DC       = 1;
  localparam int BIT_REPEAT   = 0;
  // =====================================================
  // sticky flag positions in the two flag registers
  localparam int FLG_SHORT    = 7;
  localparam int FLG_BUTTON   = 5;
  localparam int FLG_HEADSET  = 4;
  localparam int FLG_COMP     = 3;
  localparam int FLG_NOISE    = 6;
  localparam int FLG_ENGINE   = 4;
  localparam int FLG_DC       = 2;
  // =====================================================
  // timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int PULSE_MS     = 2;
  localparam int PERIOD_MS    = 4;
  localparam int PULSE_CYC    = CLK_HZ / 1000 * PULSE_MS;
  localparam int PERIOD_CYC   = CLK_HZ / 1000 * PERIOD_MS;
  localparam int CNT_W        = 18;
  localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
endpackage

// File: design/irq_gen_if.sv
// carrier between the register front and one pulse generator
`timescale 1ns/1ps
interface irq_gen_if;
  logic [7:0] cfg;
  logic [7:1] evt;
  logic       rd_dac;
  logic       rd_adc;
  logic       irq;

  modport front (output cfg, output evt, output rd_dac, output rd_adc, input irq);
  modport gen   (input cfg, input evt, input rd_dac, input rd_adc, output irq);
endinterface

// File: design/irq_pulse_gen.sv
// one interrupt output: source gating and pulse sequencing
`timescale 1ns/1ps
module irq_pulse_gen
  import irq_sel_pkg::*;
#(
  parameter int PULSE_LEN  = PULSE_CYC,
  parameter int PERIOD_LEN = PERIOD_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ce,
  irq_gen_if.gen    bus
);
  typedef enum logic [1:0] {IDLE, HIGH, LOW} gen_state_t;

  localparam logic [CNT_W-1:0] HIGH_LEN = CNT_W'(PULSE_LEN);
  localparam logic [CNT_W-1:0] LOW_LEN  = CNT_W'(PERIOD_LEN - PULSE_LEN);

  gen_state_t       state_r;
  gen_state_t       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             seen_dac_r;
  logic             seen_adc_r;
  wire logic        hit;
  wire logic        stop;
  wire logic        repeat_on;
  wire logic        last;

  // =====================================================
  // source gating: enabled sources are ORed together
  assign hit       = |(bus.cfg[7:1] & bus.evt);
  assign repeat_on = bus.cfg[BIT_REPEAT];
  assign stop      = seen_dac_r & seen_adc_r;
  assign last      = (cnt_r == CNT_ONE);
  assign bus.irq   = (state_r == HIGH);

  // sequencer: a train only ends at a pulse boundary, never mid-pulse
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      IDLE: begin
        if (hit) begin
          state_nxt = HIGH;
          cnt_nxt   = HIGH_LEN;
        end
      end
      HIGH: begin
        if (!last) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end else if (repeat_on && !stop) begin
          state_nxt = LOW;
          cnt_nxt   = LOW_LEN;
        end else begin
          state_nxt = IDLE;
        end
      end
      LOW: begin
        if (!last) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end else if (stop || !repeat_on) begin
          state_nxt = IDLE;
        end else begin
          state_nxt = HIGH;
          cnt_nxt   = HIGH_LEN;
        end
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  // state and counter registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= IDLE;
      cnt_r   <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // flag-read tracking; a fresh event re-arms, so it beats a read
  always_ff @(posedge mclk) begin
    if (sys_rst || (ce && hit)) begin
      seen_dac_r <= 1'b0;
      seen_adc_r <= 1'b0;
    end else if (ce) begin
      seen_dac_r <= seen_dac_r | bus.rd_dac;
      seen_adc_r <= seen_adc_r | bus.rd_adc;
    end
  end

  // =====================================================
  // checks
  idle_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == IDLE) && ce && hit |=> bus.irq)
    else $error("enabled event did not start a pulse");
  masked_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == IDLE) && !(ce && hit) |=> !bus.irq)
    else $error("output rose without an enabled event");
  high_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.irq |-> (cnt_r <= HIGH_LEN) && (cnt_r != '0))
    else $error("pulse counter out of range");
  single_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == HIGH) && last && ce && !repeat_on |=> !bus.irq)
    else $error("single pulse mode did not end");
  repeat_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == HIGH) && last && ce && repeat_on && !stop |=> (state_r == LOW) && (cnt_r == LOW_LEN))
    else $error("repeat mode gap wrong");
  train_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == LOW) && last && ce && stop |=> (state_r == IDLE))
    else $error("train kept running after both flag reads");
endmodule

// File: design/dual_irq_pin_source_select.sv
// register front, sticky flags and two interrupt outputs
`timescale 1ns/1ps
module dual_irq_pin_source_select
  import irq_sel_pkg::*;
#(
  parameter int PULSE_LEN  = PULSE_CYC,
  parameter int PERIOD_LEN = PERIOD_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:1] src_evt,
  output logic            irq_out_a,
  output logic            irq_out_b
);
  logic [7:0] cfg_a_r;
  logic [7:0] cfg_b_r;
  logic [7:0] flag_dac_r;
  logic [7:0] flag_dac_nxt;
  logic [7:0] flag_adc_r;
  logic [7:0] flag_adc_nxt;
  logic [7:0] rdata_nxt;
  wire logic  wr_a;
  wire logic  wr_b;
  wire logic  rd_dac;
  wire logic  rd_adc;
  wire logic  sel_a;
  wire logic  sel_b;
  wire logic  sel_dac;
  wire logic  sel_adc;
  wire logic [7:0] set_dac;
  wire logic [7:0] set_adc;

  irq_gen_if gen_a ();
  irq_gen_if gen_b ();

  // =====================================================
  // address decode; the reserved slot takes no write and reads zero
  assign wr_a   = ce && reg_wr && (reg_addr == ADDR_IRQ_A);
  assign wr_b   = ce && reg_wr && (reg_addr == ADDR_IRQ_B);
  assign rd_dac = ce && reg_rd && (reg_addr == ADDR_FLAG_DAC);
  assign rd_adc = ce && reg_rd && (reg_addr == ADDR_FLAG_ADC);

  // control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_a_r <= CFG_RESET;
      cfg_b_r <= CFG_RESET;
    end else begin
      if (wr_a) cfg_a_r <= reg_wdata;
      if (wr_b) cfg_b_r <= reg_wdata;
    end
  end

  // =====================================================
  // sticky flags: raw events mapped into the two flag registers
  assign set_dac = (({7'h00, src_evt[BIT_SHORT]}   << FLG_SHORT)
                 |  ({7'h00, src_evt[BIT_BUTTON]}  << FLG_BUTTON)
                 |  ({7'h00, src_evt[BIT_HEADSET]} << FLG_HEADSET)
                 |  ({7'h00, src_evt[BIT_COMP]}    << FLG_COMP)) & {8{ce}};
  assign set_adc = (({7'h00, src_evt[BIT_NOISE]}   << FLG_NOISE)
                 |  ({7'h00, src_evt[BIT_ENGINE]}  << FLG_ENGINE)
                 |  ({7'h00, src_evt[BIT_DC]}      << FLG_DC)) & {8{ce}};
  // read clears, but an event in the same cycle survives the read
  assign flag_dac_nxt = (rd_dac ? FLAG_RESET : flag_dac_r) | set_dac;
  assign flag_adc_nxt = (rd_adc ? FLAG_RESET : flag_adc_r) | set_adc;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_dac_r <= FLAG_RESET;
      flag_adc_r <= FLAG_RESET;
    end else begin
      flag_dac_r <= flag_dac_nxt;
      flag_adc_r <= flag_adc_nxt;
    end
  end

  // =====================================================
  // read mux, registered; unmapped and reserved addresses answer zero
  // one-hot and-or select: an address that matches nothing falls out as zero
  assign sel_a     = (reg_addr == ADDR_IRQ_A);
  assign sel_b     = (reg_addr == ADDR_IRQ_B);
  assign sel_dac   = (reg_addr == ADDR_FLAG_DAC);
  assign sel_adc   = (reg_addr == ADDR_FLAG_ADC);
  assign rdata_nxt = ({8{sel_a}} & cfg_a_r) | ({8{sel_b}} & cfg_b_r)
                   | ({8{sel_dac}} & flag_dac_r) | ({8{sel_adc}} & flag_adc_r);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // =====================================================
  // two generators, each steered by its own control register
  assign gen_a.cfg    = cfg_a_r;
  assign gen_a.evt    = src_evt;
  assign gen_a.rd_dac = rd_dac;
  assign gen_a.rd_adc = rd_adc;
  assign gen_b.cfg    = cfg_b_r;
  assign gen_b.evt    = src_evt;
  assign gen_b.rd_dac = rd_dac;
  assign gen_b.rd_adc = rd_adc;
  assign irq_out_a    = gen_a.irq;
  assign irq_out_b    = gen_b.irq;

  irq_pulse_gen #(
    .PULSE_LEN  (PULSE_LEN),
    .PERIOD_LEN (PERIOD_LEN)
  ) u_gen_a (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .bus     (gen_a.gen)
  );

  irq_pulse_gen #(
    .PULSE_LEN  (PULSE_LEN),
    .PERIOD_LEN (PERIOD_LEN)
  ) u_gen_b (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .bus     (gen_b.gen)
  );

  // =====================================================
  // checks
  cfg_reset_a: assert property (@(posedge mclk)
    sys_rst |=> (cfg_a_r == CFG_RESET) && (cfg_b_r == CFG_RESET) && !irq_out_a && !irq_out_b)
    else $error("control registers not cleared by reset");
  flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_dac && (set_dac == 8'h00) |=> (flag_dac_r == FLAG_RESET))
    else $error("flag register not cleared by its read");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !rd_adc |=> ((flag_adc_r & $past(flag_adc_r)) == $past(flag_adc_r)))
    else $error("flag dropped without a read");
  cfg_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_b |=> (cfg_b_r == $past(reg_wdata)))
    else $error("control write lost");

  // =====================================================
  // register port checks
  cfg_a_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_a |=> (cfg_a_r == $past(reg_wdata)))
    else $error("control write to output A lost");
  cfg_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !wr_a && !wr_b |=> $stable(cfg_a_r) && $stable(cfg_b_r))
    else $error("control register changed without a write");
  rdata_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && reg_rd |=> (reg_rdata == $past(rdata_nxt)))
    else $error("read data not loaded");
  rdata_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(ce && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  rsvd_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && reg_rd && (reg_addr == ADDR_RSVD) |=> (reg_rdata == 8'h00))
    else $error("reserved slot did not read zero");
  dac_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_dac |=> (reg_rdata == $past(flag_dac_r)))
    else $error("first flag register read returned wrong value");
  adc_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_adc |=> (reg_rdata == $past(flag_adc_r)))
    else $error("second flag register read returned wrong value");

  // sticky flag checks: every event lands on its own flag
  short_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_SHORT] |=> flag_dac_r[FLG_SHORT])
    else $error("short circuit flag not set");
  button_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_BUTTON] |=> flag_dac_r[FLG_BUTTON])
    else $error("button flag not set");
  headset_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_HEADSET] |=> flag_dac_r[FLG_HEADSET])
    else $error("headset flag not set");
  comp_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_COMP] |=> flag_dac_r[FLG_COMP])
    else $error("compressor flag not set");
  noise_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_NOISE] |=> flag_adc_r[FLG_NOISE])
    else $error("gain control noise flag not set");
  engine_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_ENGINE] |=> flag_adc_r[FLG_ENGINE])
    else $error("engine flag not set");
  dc_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && src_evt[BIT_DC] |=> flag_adc_r[FLG_DC])
    else $error("dc data flag not set");
  dac_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !rd_dac |=> ((flag_dac_r & $past(flag_dac_r)) == $past(flag_dac_r)))
    else $error("first flag register dropped a bit without a read");
  adc_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_adc && (set_adc == 8'h00) |=> (flag_adc_r == FLAG_RESET))
    else $error("second flag register not cleared by its read");

  // freeze and reset checks; a low enable must hold every register still
  flags_reset_a: assert property (@(posedge mclk)
    sys_rst |=> (flag_dac_r == FLAG_RESET) && (flag_adc_r == FLAG_RESET) && (reg_rdata == 8'h00))
    else $error("flags or read data not cleared by reset");
  freeze_state_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !ce |=> $stable(cfg_a_r) && $stable(cfg_b_r) && $stable(flag_dac_r) && $stable(flag_adc_r))
    else $error("register moved while enable was low");
  freeze_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !ce |=> $stable(irq_out_a) && $stable(irq_out_b) && $stable(reg_rdata))
    else $error("output moved while enable was low");
endmodule

// File: test/irq_host_model.sv
// host-side interrupt input: counts pulses on one line and keeps the last width
`timescale 1ns/1ps
module irq_host_model (
  input  wire logic mclk,
  input  wire logic irq,
  output int        pulses,
  output int        width
);
  int run = 0;
  // ==========================================
  // edge and width capture
  // the width lands only when the line falls, so a stuck-high line never reports
  always @(posedge mclk) begin
    if (irq) begin
      run <= run + 1;
      if (run == 0) pulses <= pulses + 1;
    end else begin
      if (run != 0) width <= run;
      run <= 0;
    end
  end
endmodule

// File: test/tb.sv
// self-checking bench for the two-output interrupt source select block
`timescale 1ns/1ps
module tb;
  import irq_sel_pkg::*;
  localparam int PL = 4;
  localparam int PP = 8;
  logic       mclk      = 1'b0;
  logic       sys_rst   = 1'b1;
  logic       ce        = 1'b1;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:1] src_evt   = 7'h00;
  logic       irq_out_a;
  logic       irq_out_b;
  logic       rd_d      = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] v;
  int         pa, pb, wa, wb, n;
  int         errors    = 0;
  int         tests_run = 0;
  int         cyc       = 0;
  // flag register and bit of each source, indexed like the control bits
  int         fbit  [8] = '{0, FLG_DC, FLG_ENGINE, FLG_SHORT, FLG_NOISE, FLG_COMP, FLG_BUTTON, FLG_HEADSET};
  logic [7:0] faddr [8] = '{8'h00, ADDR_FLAG_ADC, ADDR_FLAG_ADC, ADDR_FLAG_DAC, ADDR_FLAG_ADC, ADDR_FLAG_DAC,
                            ADDR_FLAG_DAC, ADDR_FLAG_DAC};

  always #12.5 mclk = ~mclk;

  dual_irq_pin_source_select #(.PULSE_LEN(PL), .PERIOD_LEN(PP)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_evt(src_evt), .irq_out_a(irq_out_a),
    .irq_out_b(irq_out_b));
  irq_host_model host_a (.mclk(mclk), .irq(irq_out_a), .pulses(pa), .width(wa));
  irq_host_model host_b (.mclk(mclk), .irq(irq_out_b), .pulses(pb), .width(wb));

  // ==========================================
  // checking and bus tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // read data is noted here and judged by the watcher a cycle later
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask

  task automatic fire(int i);
    @(negedge mclk);
    src_evt[i] = 1'b1;
    @(negedge mclk);
    src_evt = 7'h00;
  endtask

  task automatic idle(int k);
    repeat (k) @(negedge mclk);
  endtask

  // ==========================================
  // watcher and hang guard
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  always @(negedge mclk) begin
    if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h9A22));
    idle(4);
    sys_rst = 1'b0;
    rd(ADDR_IRQ_A, CFG_RESET);
    rd(ADDR_IRQ_B, CFG_RESET);
    rd(ADDR_FLAG_DAC, FLAG_RESET);
    v = 8'($urandom);
    wr(ADDR_IRQ_A, v);
    wr(ADDR_IRQ_B, ~v);
    rd(ADDR_IRQ_A, v);
    rd(ADDR_IRQ_B, ~v);
    wr(ADDR_RSVD, 8'h00);
    rd(ADDR_RSVD, 8'h00);
    rd(8'h7E, 8'h00);
    $display("test registers done");
    // each source alone: output A has only it, output B has all the others
    for (int i = 1; i < 8; i++) begin
      wr(ADDR_IRQ_A, 8'h01 << i);
      wr(ADDR_IRQ_B, 8'hFE ^ (8'h01 << i));
      fire(i);
      idle(PL + 2 + $urandom_range(3));
      chk("irq_a pulses", i, pa);
      chk("irq_b pulses", 0, pb);
      chk("irq_a width", PL, wa);
      rd(faddr[i], 8'h01 << fbit[i]);
      rd(faddr[i] ^ 8'h01, 8'h00);
      rd(faddr[i], 8'h00);
    end
    $display("test sources done");
    // repeat mode on B; one flag register read alone must not stop it
    wr(ADDR_IRQ_A, 8'h00);
    wr(ADDR_IRQ_B, 8'h81);
    fire(7);
    idle(3 * PP - 2);
    chk("irq_b train", 3, pb);
    chk("irq_b width", PL, wb);
    rd(ADDR_FLAG_DAC, 8'h01 << FLG_HEADSET);
    n = pb;
    idle(2 * PP);
    chk("irq_b running", n + 2, pb);
    idle(PL); // last read lands in a gap, so the train ends from its low phase
    rd(ADDR_FLAG_ADC, 8'h00);
    idle(2 * PP);
    n = pb;
    idle(3 * PP);
    chk("irq_b stopped", n, pb);
    chk("irq_b level", 1'b0, irq_out_b);
    chk("irq_a quiet", 7, pa);
    $display("test repeat done");
    // enable low stretches a pulse by the frozen cycles and drops a write
    wr(ADDR_IRQ_A, 8'h80);
    fire(7);
    ce = 1'b0;
    wr(ADDR_IRQ_A, 8'h00);
    idle(1);
    ce = 1'b1;
    idle(PL + 2);
    chk("irq_a frozen width", PL + 3, wa);
    chk("irq_a frozen pulses", 8, pa);
    rd(ADDR_IRQ_A, 8'h80);
    // reset in mid-train on B: controls back to zero, line B drops, line A is already low
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    chk("irq_b after reset", 1'b0, irq_out_b);
    chk("irq_a after reset", 1'b0, irq_out_a);
    rd(ADDR_IRQ_A, CFG_RESET);
    rd(ADDR_IRQ_B, CFG_RESET);
    $display("test freeze and reset done");
    final_report();
  end
endmodule
